// ---- bench/lapi_checker.sv ----
`timescale 1ns/1ps
`default_nettype none
// ****************
// Port checker
// ****************
module lapi_checker (
    // Clock and reset
    input wire logic clk,
    input wire logic arst_n,
    // Stimulus side
    input wire logic reg_wr_en,
    input wire logic [4:0] reg_wr_addr,
    input wire logic [7:0] reg_wr_data,
    input wire logic [4:0] reg_rd_addr,
    input wire logic cmd_manual_stop,
    input wire logic interrupt_pending_flag,
    // Design outputs
    input wire logic [7:0] reg_rd_data,
    input wire logic dev_powered,
    input wire logic adc_active,
    input wire logic adc_cycle_done,
    input wire logic adc_valid,
    input wire logic manual_mode,
    input wire logic [15:0] manual_timer
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!arst_n);
    sequence s_ctl_wr; reg_wr_en && reg_wr_addr == 5'h00; endsequence
    sequence s_ctl_rd; reg_rd_addr == 5'h00; endsequence
    sequence s_stop; cmd_manual_stop && manual_mode && adc_active; endsequence
    sequence s_end; adc_cycle_done && adc_valid && !adc_active; endsequence
    property p_pwr; s_ctl_wr |=> dev_powered == $past(reg_wr_data[0]);
    endproperty
    a_pwr: assert property (p_pwr) else $error("power bit wrong");
    property p_act; adc_active |-> dev_powered; endproperty
    a_act: assert property (p_act) else $error("active unpowered");
    property p_vclr; !dev_powered |=> !adc_valid; endproperty
    a_vclr: assert property (p_vclr) else $error("valid unpowered");
    property p_dval; adc_cycle_done |-> adc_valid; endproperty
    a_dval: assert property (p_dval) else $error("done without valid");
    property p_dpls; adc_cycle_done |=> !adc_cycle_done; endproperty
    a_dpls: assert property (p_dpls) else $error("done too long");
    property p_intr;
        s_ctl_rd |=> reg_rd_data[5] == $past(interrupt_pending_flag);
    endproperty
    a_intr: assert property (p_intr) else $error("intr bit wrong");
    property p_rsv;
        s_ctl_rd |=> reg_rd_data[7:6] == 2'h0 && reg_rd_data[3:2] == 2'h0;
    endproperty
    a_rsv: assert property (p_rsv) else $error("reserved bits set");
    property p_stop; s_stop |=> s_end; endproperty
    a_stop: assert property (p_stop) else $error("manual stop wrong");
    property p_mq; !manual_mode |=> $stable(manual_timer); endproperty
    a_mq: assert property (p_mq) else $error("timer moved");
endmodule // lapi_checker

bind lapi_top lapi_checker u_lapi_checker (.clk, .arst_n, .reg_wr_en,
    .reg_wr_addr, .reg_wr_data, .reg_rd_addr, .cmd_manual_stop,
    .interrupt_pending_flag, .reg_rd_data, .dev_powered, .adc_active,
    .adc_cycle_done, .adc_valid, .manual_mode, .manual_timer);
`default_nettype wire

// ---- bench/lapi_host_model.sv ----
`timescale 1ns/1ps
`default_nettype none
// ****************
// Host model
// ****************
module lapi_host_model #(
    parameter integer PWR_CYC = 80000
) (
    // Clock
    input wire logic clk,
    // Register write port
    output logic reg_wr_en,
    output logic [4:0] reg_wr_addr,
    output logic [7:0] reg_wr_data
);
    initial begin
        reg_wr_en = 1'b0;
        reg_wr_addr = 5'h1f;
        reg_wr_data = 8'h00;
    end
    task automatic wr(input logic [4:0] a, input logic [7:0] d);
        @(posedge clk);
        #2;
        reg_wr_en = 1'b1;
        reg_wr_addr = a;
        reg_wr_data = d;
        @(posedge clk);
        #2;
        reg_wr_en = 1'b0;
        reg_wr_addr = ~a;
        reg_wr_data = ~d;
    endtask
    task automatic ctrl(input logic en, input logic pwr);
        wr(5'h00, {6'h00, en, pwr});
    endtask
    task automatic pwr_up;
        ctrl(1'b0, 1'b1);
        repeat (PWR_CYC) @(posedge clk);
    endtask
endmodule // lapi_host_model
`default_nettype wire

// ---- bench/light_adc_power_integration_bench.sv ----
`timescale 1ns/1ps
`default_nettype none
// ****************
// Bench
// ****************
module light_adc_power_integration_bench;
    localparam integer STEP = 4;
    logic clk = 1'b0;
    logic arst_n = 1'b0;
    logic [4:0] reg_rd_addr = 5'h00;
    logic cmd_manual_start = 1'b0;
    logic cmd_manual_stop = 1'b0;
    logic interrupt_pending_flag = 1'b0;
    logic reg_wr_en;
    logic [4:0] reg_wr_addr;
    logic [7:0] reg_wr_data;
    logic [7:0] reg_rd_data;
    logic dev_powered, adc_active, adc_cycle_done, adc_valid, manual_mode;
    logic [15:0] manual_timer;
    logic rd_go = 1'b0;
    logic rd_go_q = 1'b0;
    logic [7:0] exp_q[$];
    logic [7:0] codes [0:2] = '{8'hff, 8'hfe, 8'h01};
    integer error_cnt = 0;
    integer checks = 0;
    integer seed = 51;
    integer n, p, i;
    always #12.5 clk = ~clk;
    lapi_host_model u_lapi_host_model (.clk(clk), .reg_wr_en(reg_wr_en),
        .reg_wr_addr(reg_wr_addr), .reg_wr_data(reg_wr_data));
    lapi_top #(.STEP_CYCLES(STEP)) u_lapi_top (.clk(clk), .arst_n(arst_n),
        .reg_wr_en(reg_wr_en), .reg_wr_addr(reg_wr_addr),
        .reg_wr_data(reg_wr_data), .reg_rd_addr(reg_rd_addr),
        .reg_rd_data(reg_rd_data), .cmd_manual_start(cmd_manual_start),
        .cmd_manual_stop(cmd_manual_stop),
        .interrupt_pending_flag(interrupt_pending_flag),
        .dev_powered(dev_powered), .adc_active(adc_active),
        .adc_cycle_done(adc_cycle_done), .adc_valid(adc_valid),
        .manual_mode(manual_mode), .manual_timer(manual_timer));
    task chk(input logic [15:0] e, input logic [15:0] a);
        checks = checks + 1;
        if (a !== e) begin
            error_cnt = error_cnt + 1;
            $display("Error at %0t: exp %h got %h", $time, e, a);
        end
    endtask
    task summarize;
        if (error_cnt == 0 && checks > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    task rd(input logic [4:0] a, input logic [7:0] e);
        @(posedge clk);
        #2;
        reg_rd_addr = a;
        rd_go = 1'b1;
        exp_q.push_back(e);
        @(posedge clk);
        #2;
        rd_go = 1'b0;
    endtask
    // ****************
    // Result watcher
    // ****************
    always @(posedge clk) rd_go_q <= rd_go;
    always @(negedge clk) if (rd_go_q) chk(exp_q.pop_front(), reg_rd_data);
    task cmd(input logic st);
        @(posedge clk);
        #2;
        if (st) cmd_manual_start = 1'b1;
        else cmd_manual_stop = 1'b1;
        @(posedge clk);
        #2;
        cmd_manual_start = 1'b0;
        cmd_manual_stop = 1'b0;
    endtask
    task period;
        p = 0;
        n = 0;
        while (adc_cycle_done !== 1'b1 && n < 2000) begin
            @(posedge clk);
            #2;
            n = n + 1;
        end
        do begin
            @(posedge clk);
            #2;
            p = p + 1;
        end while (adc_cycle_done !== 1'b1 && p < 2000);
        if (n >= 2000 || p >= 2000) begin
            error_cnt = error_cnt + 1;
            summarize;
        end
    endtask
    initial begin
        repeat (2) @(posedge clk);
        #2;
        arst_n = 1'b1;
        rd(5'h01, 8'h00);
        rd(5'h00, 8'h00);
        chk(16'h1, 16'(manual_mode));
        u_lapi_host_model.pwr_up;
        rd(5'h00, 8'h01);
        u_lapi_host_model.ctrl(1'b1, 1'b1);
        chk(16'h0, 16'(adc_active));
        cmd(1'b1);
        chk(16'h1, 16'(adc_active));
        repeat (5 * STEP) @(posedge clk);
        cmd(1'b0);
        chk(16'h1, 16'(adc_cycle_done));
        chk(16'h1, 16'(manual_timer >= 4 && manual_timer <= 6));
        for (i = 0; i < 3; i = i + 1) begin
            u_lapi_host_model.ctrl(1'b0, 1'b1);
            u_lapi_host_model.wr(5'h01, codes[i]);
            u_lapi_host_model.ctrl(1'b1, 1'b1);
            period;
            chk(16'((256 - codes[i]) * STEP), 16'(p));
        end
        interrupt_pending_flag = $random(seed);
        rd(5'h00, {2'h0, interrupt_pending_flag, 5'h13});
        u_lapi_host_model.ctrl(1'b0, 1'b1);
        @(posedge clk);
        #2;
        chk(16'h0, 16'({adc_active, adc_valid}));
        u_lapi_host_model.ctrl(1'b0, 1'b0);
        chk(16'h0, 16'(dev_powered));
        u_lapi_host_model.wr(5'h02, 8'($random(seed)));
        rd(5'h02, 8'h00);
        rd(5'h01, 8'h01);
        @(posedge clk);
        #2 arst_n = 1'b0;
        @(posedge clk);
        #2 arst_n = 1'b1;
        rd(5'h01, 8'h00);
        summarize;
    end
endmodule // light_adc_power_integration_bench
`default_nettype wire

// ---- pkg/lapi_map.vh ----
`ifndef LAPI_MAP_VH
`define LAPI_MAP_VH

// ****************************************
// Register offsets
// ****************************************
`define LAPI_ADDR_CTRL 5'h00
`define LAPI_ADDR_ITIME 5'h01

// ****************************************
// Control register fields
// ****************************************
`define LAPI_CTRL_POWER_BIT 0
`define LAPI_CTRL_EN_BIT 1
`define LAPI_CTRL_VALID_BIT 4
`define LAPI_CTRL_INTR_BIT 5
`define LAPI_CTRL_RESET 8'h00

// ****************************************
// Integration time register
// ****************************************
`define LAPI_ITIME_RESET 8'h00
`define LAPI_ITIME_MANUAL 8'h00
`define LAPI_STEP_SPAN 9'h100

// ****************************************
// Timing counts
// ****************************************
`define LAPI_CLK_NS 25
`define LAPI_STEP_NS 2700000
`define LAPI_STEP_CYC ((`LAPI_STEP_NS) / (`LAPI_CLK_NS))
`define LAPI_STEP_CNT_W 17

`endif

// ---- rtl/lapi_step_timer.v ----
`timescale 1ns/1ps
`default_nettype none

module lapi_step_timer #(
    parameter integer STEP_CYCLES = 108000
) (
    // Clock and reset
    input wire clk,
    input wire arst_n,
    // Control
    input wire restart,
    input wire run,
    // Step tick
    output reg tick
);

    localparam integer LAST = STEP_CYCLES - 1;

    reg [16:0] cnt_ff;
    reg [16:0] nxt_cnt;
    reg nxt_tick;

    // ****************************************
    // Step prescaler
    // ****************************************
    always @* begin
        nxt_cnt = cnt_ff;
        nxt_tick = 1'b0;
        if (restart || !run) begin
            nxt_cnt = 17'h00000;
        end else if ({15'h0000, cnt_ff} >= LAST) begin
            nxt_cnt = 17'h00000;
            nxt_tick = 1'b1;
        end else begin
            nxt_cnt = cnt_ff + 17'h00001;
        end
    end

    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            cnt_ff <= 17'h00000;
            tick <= 1'b0;
        end else begin
            cnt_ff <= nxt_cnt;
            tick <= nxt_tick;
        end
    end

endmodule // lapi_step_timer

`default_nettype wire

// ---- rtl/lapi_top.v ----
`timescale 1ns/1ps
`default_nettype none
`include "lapi_map.vh"

module lapi_top #(
    parameter integer STEP_CYCLES = `LAPI_STEP_CYC
) (
    // Clock and reset
    input wire clk,
    input wire arst_n,
    // Register write port
    input wire reg_wr_en,
    input wire [4:0] reg_wr_addr,
    input wire [7:0] reg_wr_data,
    // Register read port
    input wire [4:0] reg_rd_addr,
    output reg [7:0] reg_rd_data,
    // Decoded commands
    input wire cmd_manual_start,
    input wire cmd_manual_stop,
    // Interrupt state from interrupt logic
    input wire interrupt_pending_flag,
    // Converter control
    output wire dev_powered,
    output wire adc_active,
    output reg adc_cycle_done,
    output wire adc_valid,
    output wire manual_mode,
    output reg [15:0] manual_timer
);

    // ****************************************
    // Declarations
    // ****************************************
    reg power_ff;
    reg nxt_power;
    reg adc_en_ff;
    reg nxt_adc_en;
    reg [7:0] integration_time_code_ff;
    reg [7:0] nxt_integration_time_code;
    reg enabled_q_ff;
    reg valid_ff;
    reg nxt_valid;
    reg [8:0] step_cnt_ff;
    reg [8:0] nxt_step_cnt;
    reg man_run_ff;
    reg nxt_man_run;
    reg [15:0] man_cnt_ff;
    reg [15:0] nxt_man_cnt;
    reg [15:0] nxt_manual_timer;
    reg nxt_cycle_done;
    reg [7:0] nxt_rd_data;
    wire wr_ctrl;
    wire wr_itime;
    wire enabled;
    wire enable_rise;
    wire timed_run;
    wire man_start;
    wire man_stop;
    wire step_tick;
    wire step_restart;
    wire step_run;
    wire [8:0] steps_needed;
    wire [8:0] step_cnt_inc;
    wire [7:0] ctrl_view;

    // ****************************************
    // Register write decode
    // ****************************************
    assign wr_ctrl = reg_wr_en && (reg_wr_addr == `LAPI_ADDR_CTRL);
    assign wr_itime = reg_wr_en && (reg_wr_addr == `LAPI_ADDR_ITIME);

    // ****************************************
    // Control register
    // ****************************************
    always @* begin
        nxt_power = power_ff;
        nxt_adc_en = adc_en_ff;
        if (wr_ctrl) begin
            nxt_power = reg_wr_data[`LAPI_CTRL_POWER_BIT];
            nxt_adc_en = reg_wr_data[`LAPI_CTRL_EN_BIT];
        end
    end

    // ****************************************
    // Integration time register
    // ****************************************
    always @* begin
        nxt_integration_time_code = integration_time_code_ff;
        if (wr_itime) begin
            nxt_integration_time_code = reg_wr_data;
        end
    end

    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            power_ff <= 1'b0;
            adc_en_ff <= 1'b0;
            integration_time_code_ff <= `LAPI_ITIME_RESET;
        end else begin
            power_ff <= nxt_power;
            adc_en_ff <= nxt_adc_en;
            integration_time_code_ff <= nxt_integration_time_code;
        end
    end

    // ****************************************
    // Run conditions
    // ****************************************
    // needs power and enable
    assign enabled = power_ff && adc_en_ff;
    assign enable_rise = enabled && !enabled_q_ff;
    assign manual_mode = (integration_time_code_ff == `LAPI_ITIME_MANUAL);
    assign timed_run = enabled && !manual_mode;

    assign man_start = enabled && manual_mode && cmd_manual_start;
    assign man_stop = enabled && manual_mode && man_run_ff && cmd_manual_stop;

    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            enabled_q_ff <= 1'b0;
        end else begin
            enabled_q_ff <= enabled;
        end
    end

    // ****************************************
    // Step timer
    // ****************************************
    assign step_restart = enable_rise || man_start;
    assign step_run = timed_run || (enabled && manual_mode && man_run_ff);

    lapi_step_timer #(
        .STEP_CYCLES(STEP_CYCLES)
    ) u_step_timer (
        .clk(clk),
        .arst_n(arst_n),
        .restart(step_restart),
        .run(step_run),
        .tick(step_tick)
    );

    // ****************************************
    // Timed integration
    // ****************************************
    // two's complement count
    assign steps_needed = `LAPI_STEP_SPAN - {1'b0, integration_time_code_ff};
    assign step_cnt_inc = step_cnt_ff + 9'h001;

    always @* begin
        nxt_step_cnt = step_cnt_ff;
        nxt_cycle_done = 1'b0;
        if (!timed_run || enable_rise) begin
            nxt_step_cnt = 9'h000;
        end else if (step_tick) begin
            if (step_cnt_inc >= steps_needed) begin
                nxt_step_cnt = 9'h000;
                nxt_cycle_done = 1'b1;
            end else begin
                nxt_step_cnt = step_cnt_inc;
            end
        end
        if (man_stop) begin
            nxt_cycle_done = 1'b1;
        end
    end

    // ****************************************
    // Manual integration
    // ****************************************
    always @* begin
        nxt_man_run = man_run_ff;
        nxt_man_cnt = man_cnt_ff;
        nxt_manual_timer = manual_timer;
        if (!enabled || !manual_mode) begin
            nxt_man_run = 1'b0;
            nxt_man_cnt = 16'h0000;
        end else if (man_start) begin
            nxt_man_run = 1'b1;
            nxt_man_cnt = 16'h0000;
        end else if (man_stop) begin
            nxt_man_run = 1'b0;
            nxt_manual_timer = man_cnt_ff;
        end else if (man_run_ff && step_tick && (man_cnt_ff != 16'hffff)) begin
            nxt_man_cnt = man_cnt_ff + 16'h0001;
        end
    end

    // ****************************************
    // Valid flag
    // ****************************************
    always @* begin
        nxt_valid = valid_ff;
        if (!enabled) begin
            nxt_valid = 1'b0;
        end
        if (nxt_cycle_done) begin
            nxt_valid = 1'b1;
        end
    end

    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            step_cnt_ff <= 9'h000;
            man_run_ff <= 1'b0;
            man_cnt_ff <= 16'h0000;
            manual_timer <= 16'h0000;
            adc_cycle_done <= 1'b0;
            valid_ff <= 1'b0;
        end else begin
            step_cnt_ff <= nxt_step_cnt;
            man_run_ff <= nxt_man_run;
            man_cnt_ff <= nxt_man_cnt;
            manual_timer <= nxt_manual_timer;
            adc_cycle_done <= nxt_cycle_done;
            valid_ff <= nxt_valid;
        end
    end

    // ****************************************
    // Read back
    // ****************************************
    // control register view: interrupt flag, valid, enable and power bits
    assign ctrl_view = {2'b00, interrupt_pending_flag, valid_ff,
                        2'b00, adc_en_ff, power_ff};

    always @* begin
        case (reg_rd_addr)
            `LAPI_ADDR_CTRL: begin
                nxt_rd_data = ctrl_view;
            end
            `LAPI_ADDR_ITIME: begin
                nxt_rd_data = integration_time_code_ff;
            end
            default: begin
                nxt_rd_data = 8'h00;
            end
        endcase
    end

    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            reg_rd_data <= 8'h00;
        end else begin
            reg_rd_data <= nxt_rd_data;
        end
    end

    // ****************************************
    // Outputs
    // ****************************************
    assign dev_powered = power_ff;
    assign adc_active = step_run;
    assign adc_valid = valid_ff;

endmodule // lapi_top

`default_nettype wire
